//--- include/uhp_pkg.sv
// Constants of the host frame and pipe control block.
// Assumes a 10 MHz core clock and a 12-bit byte register address.
package uhp_pkg;

   localparam int unsigned UHP_NPIPE = 7;
   localparam int unsigned UHP_AW = 12;

   // Register offsets
   localparam logic [11:0] UHP_OFF_IRQ_STATUS = 12'h404;
   localparam logic [11:0] UHP_OFF_IRQ_CLEAR = 12'h408;
   localparam logic [11:0] UHP_OFF_IRQ_MASK = 12'h410;
   localparam logic [11:0] UHP_OFF_IRQ_MASK_CLR = 12'h414;
   localparam logic [11:0] UHP_OFF_IRQ_MASK_SET = 12'h418;
   localparam logic [11:0] UHP_OFF_PIPE_EN = 12'h41c;
   localparam logic [11:0] UHP_OFF_FRAME = 12'h420;
   localparam logic [11:0] UHP_OFF_ADDR_LO = 12'h424;
   localparam logic [11:0] UHP_OFF_ADDR_HI = 12'h428;
   localparam logic [11:0] UHP_OFF_CFG_BASE = 12'h500;
   localparam logic [11:0] UHP_OFF_CFG_STRIDE = 12'h004;
   localparam logic [31:0] UHP_RESET_VAL = 32'h0000_0000;

   // Interrupt bit layout, shared by status, mask, clear and set
   localparam int unsigned UHP_IRQ_RESUME_SENT = 3;
   localparam int unsigned UHP_IRQ_UPSTREAM = 4;
   localparam int unsigned UHP_IRQ_SOF = 5;
   localparam int unsigned UHP_IRQ_WAKEUP = 6;
   localparam int unsigned UHP_IRQ_PIPE_LSB = 8;
   localparam int unsigned UHP_IRQ_DMA_LSB = 25;
   localparam int unsigned UHP_NDMA = 6;
   localparam logic [31:0] UHP_IRQ_VALID = 32'h7e00_7f78;

   // Frame register fields
   localparam int unsigned UHP_FRAME_NUMBER_LSB = 3;
   localparam int unsigned UHP_FRAME_NUMBER_W = 11;
   localparam int unsigned UHP_FLEN_LSB = 16;
   localparam int unsigned UHP_FLEN_W = 8;
   localparam int unsigned UHP_FCNT_W = 14;

   // Frame timing
   localparam int unsigned UHP_FRAME_LEN_COUNTS = 12000;
   localparam int unsigned UHP_USB_CLK_HZ = 12_000_000;
   localparam int unsigned UHP_CORE_CLK_HZ = 10_000_000;
   localparam int unsigned UHP_EXTRA_EVERY =
      UHP_CORE_CLK_HZ / (UHP_USB_CLK_HZ - UHP_CORE_CLK_HZ);

   // Address and enable/reset fields
   localparam int unsigned UHP_ADDR_W = 7;
   localparam int unsigned UHP_ADDR_STRIDE = 8;
   localparam int unsigned UHP_ADDR_LO_PIPES = 4;
   localparam int unsigned UHP_PEN_LSB = 0;
   localparam int unsigned UHP_PRST_LSB = 16;

   // Pipe configuration fields
   localparam int unsigned UHP_PIPE_MEMORY_ALLOCATE_BIT = 1;
   localparam int unsigned UHP_PBK_LSB = 2;
   localparam int unsigned UHP_PIPE_BANK_SIZE_LSB = 4;
   localparam int unsigned UHP_TOKEN_LSB = 8;
   localparam int unsigned UHP_AUTO_BANK_SWITCH_BIT = 10;
   localparam int unsigned UHP_PIPE_TRANSFER_TYPE_LSB = 12;
   localparam int unsigned UHP_EPNUM_LSB = 16;
   localparam int unsigned UHP_PIPE_POLLING_INTERVAL_LSB = 24;
   localparam logic [1:0] UHP_TOKEN_RSVD = 2'h3;
   localparam logic [11:0] UHP_BANK_BASE_BYTES = 12'h008;
   localparam int unsigned UHP_MEM_W = 12;

   typedef enum logic [1:0] {
      UHP_TOKEN_SETUP,
      UHP_TOKEN_IN,
      UHP_TOKEN_OUT
   } uhp_token_e;

endpackage : uhp_pkg

//--- rtl/uhp_frame_timer.sv
// Frame counter: 12 MHz count rate built from the core clock.
// Assumes the core clock runs at the rate given in the package.
`timescale 1ns/1ps
`default_nettype none
module uhp_frame_timer
   import uhp_pkg::*;
#(
   parameter int unsigned FRAME_LEN = UHP_FRAME_LEN_COUNTS
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Frame outputs
   output logic o_sof,
   output logic [UHP_FCNT_W-1:0] o_count
);

   localparam logic [UHP_FCNT_W:0] LEN = (UHP_FCNT_W+1)'(FRAME_LEN);
   localparam logic [2:0] PH_LAST = 3'(UHP_EXTRA_EVERY - 1);

   logic [UHP_FCNT_W-1:0] cnt_r;
   logic [2:0] phase_r;
   logic sof_r;
   logic [UHP_FCNT_W:0] sum;

   // Six counts for every five core cycles
   assign sum = {1'b0, cnt_r} + ((phase_r == PH_LAST) ? 15'h0002 : 15'h0001);

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         phase_r <= 3'h0;
      end else if (phase_r == PH_LAST) begin
         phase_r <= 3'h0;
      end else begin
         phase_r <= phase_r + 3'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         cnt_r <= '0;
         sof_r <= 1'b0;
      end else if (sum >= LEN) begin // R3
         cnt_r <= UHP_FCNT_W'(sum - LEN);
         sof_r <= 1'b1;
      end else begin
         cnt_r <= UHP_FCNT_W'(sum);
         sof_r <= 1'b0;
      end
   end

   assign o_sof = sof_r;
   assign o_count = cnt_r;

endmodule : uhp_frame_timer
`default_nettype wire

//--- rtl/uhp_host_ctrl.sv
// Host frame, pipe address, pipe enable/reset and pipe configuration
// registers with interrupt status, mask and one level interrupt.
// Assumes all event inputs come from logic on the core clock.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: writing ones sets interrupt enables only
// R2: frame number field, software may overwrite
// R3: 12000-count frame counter, one frame per ms
// R4: counter upper eight bits readable in frame register
// R5: software loads 7-bit device address per pipe
// R6: bus reset clears all pipe addresses
// R7: enable bit activates its pipe
// R8: disabling resets pipe, keeps allocation, banks, size
// R9: pipe reset clears FIFO, keeps configuration fields; the code clears the auto bank switch bit on pipe reset
// R10: reset reinitialises FIFO machinery, keeps data toggle
// R11: during reset configuration stays, pipe enabled; the code clears the auto bank switch bit
// R12: FIFO held until software clears reset bit
// R13: one configuration register per pipe, stride four
// R14: allocate bit reserves memory by banks, size
// R15: software clears allocate before changing allocation
// R16: bus reset clears memory allocate bits
// R17: size code selects 8 to 1024 bytes
// R18: token codes SETUP, IN, OUT; code three reserved
// R19: configuration field positions as laid out
module uhp_host_ctrl
   import uhp_pkg::*;
#(
   parameter int unsigned FRAME_LEN = UHP_FRAME_LEN_COUNTS
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Register port
   input wire logic [UHP_AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Events from the rest of the host
   input wire logic i_bus_reset_req,
   input wire logic i_resume_sent,
   input wire logic i_upstream_resume,
   input wire logic i_wakeup,
   input wire logic [UHP_NPIPE-1:0] i_pipe_event,
   input wire logic [UHP_NDMA-1:0] i_dma_event,
   // Frame outputs
   output logic o_sof,
   output logic [UHP_FRAME_NUMBER_W-1:0] o_frame_number,
   // Pipe outputs
   output logic [UHP_NPIPE-1:0] o_pipe_active,
   output logic [UHP_NPIPE-1:0] o_pipe_fifo_reset,
   output logic [UHP_NPIPE-1:0][UHP_ADDR_W-1:0] o_pipe_dev_addr,
   output logic [UHP_NPIPE-1:0][1:0] o_pipe_token,
   output logic [UHP_NPIPE-1:0][1:0] o_pipe_type,
   output logic [UHP_NPIPE-1:0][3:0] o_pipe_epnum,
   output logic [UHP_NPIPE-1:0][7:0] o_pipe_interval,
   output logic [UHP_NPIPE-1:0] o_pipe_auto_bank_switch,
   output logic [UHP_NPIPE-1:0][UHP_MEM_W-1:0] o_pipe_mem_bytes,
   // Interrupt
   output logic o_irq
);

   localparam int FRAME_CYCLES =
      int'(FRAME_LEN) * int'(UHP_CORE_CLK_HZ / 1000)
      / int'(UHP_USB_CLK_HZ / 1000);

   // Bank bytes for a size code: 8 shifted by the code
   function automatic logic [UHP_MEM_W-1:0] bank_bytes(
      input logic [2:0] code
   );
      bank_bytes = UHP_BANK_BASE_BYTES << code; // R17
   endfunction : bank_bytes

   function automatic logic wr_hit(
      input logic wr,
      input logic [UHP_AW-1:0] addr,
      input logic [UHP_AW-1:0] off
   );
      wr_hit = wr && (addr == off);
   endfunction : wr_hit

   logic [31:0] status_r;
   logic [31:0] mask_r;
   logic [31:0] rd_data_r;
   logic [UHP_FRAME_NUMBER_W-1:0] frame_number_r;
   logic [UHP_NPIPE-1:0] pen_r;
   logic [UHP_NPIPE-1:0] prst_r;
   logic [UHP_NPIPE-1:0][UHP_ADDR_W-1:0] addr_r;
   logic [UHP_NPIPE-1:0] pipe_memory_allocate_r;
   logic [UHP_NPIPE-1:0][1:0] pbk_r;
   logic [UHP_NPIPE-1:0][2:0] pipe_bank_size_r;
   logic [UHP_NPIPE-1:0][1:0] token_r;
   logic [UHP_NPIPE-1:0] auto_bank_switch_r;
   logic [UHP_NPIPE-1:0][1:0] pipe_transfer_type_r;
   logic [UHP_NPIPE-1:0][3:0] epnum_r;
   logic [UHP_NPIPE-1:0][7:0] pipe_polling_interval_r;
   logic [UHP_NPIPE-1:0] wr_cfg;
   logic [UHP_NPIPE-1:0][31:0] cfg_word;
   logic [31:0] events;
   logic [31:0] rd_nxt;
   logic [UHP_FCNT_W-1:0] fcount;
   logic sof;
   logic wr_pen;

   uhp_frame_timer #(
      .FRAME_LEN(FRAME_LEN)
   ) u_frame_timer (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .o_sof(sof),
      .o_count(fcount)
   );

   // Interrupt events gathered into the shared layout
   always_comb begin
      events = '0;
      events[UHP_IRQ_RESUME_SENT] = i_resume_sent;
      events[UHP_IRQ_UPSTREAM] = i_upstream_resume;
      events[UHP_IRQ_SOF] = sof;
      events[UHP_IRQ_WAKEUP] = i_wakeup;
      events[UHP_IRQ_PIPE_LSB +: UHP_NPIPE] = i_pipe_event;
      events[UHP_IRQ_DMA_LSB +: UHP_NDMA] = i_dma_event;
   end

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         status_r <= UHP_RESET_VAL;
      end else if (wr_hit(i_wr, i_addr, UHP_OFF_IRQ_CLEAR)) begin
         status_r <= (status_r & ~i_wdata) | events;
      end else begin
         status_r <= status_r | events;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         mask_r <= UHP_RESET_VAL;
      end else if (wr_hit(i_wr, i_addr, UHP_OFF_IRQ_MASK_SET)) begin
         mask_r <= mask_r | (i_wdata & UHP_IRQ_VALID); // R1
      end else if (wr_hit(i_wr, i_addr, UHP_OFF_IRQ_MASK_CLR)) begin
         mask_r <= mask_r & ~i_wdata;
      end
   end

   assign o_irq = |(status_r & mask_r);

   // Frame number: a software load wins over a start of frame
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         frame_number_r <= '0;
      end else if (wr_hit(i_wr, i_addr, UHP_OFF_FRAME)) begin
         frame_number_r <= i_wdata[UHP_FRAME_NUMBER_LSB +: UHP_FRAME_NUMBER_W]; // R2
      end else if (sof) begin
         frame_number_r <= frame_number_r + 11'h001; // R3
      end
   end

   assign o_sof = sof;
   assign o_frame_number = frame_number_r;

   assign wr_pen = wr_hit(i_wr, i_addr, UHP_OFF_PIPE_EN);

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         pen_r <= '0;
         prst_r <= '0;
      end else if (wr_pen) begin
         pen_r <= i_wdata[UHP_PEN_LSB +: UHP_NPIPE]; // R7
         prst_r <= i_wdata[UHP_PRST_LSB +: UHP_NPIPE]; // R12
      end
   end

   // Reset bit does not touch enable; FIFO held while it stands
   assign o_pipe_active = pen_r; // R11
   assign o_pipe_fifo_reset = prst_r; // R10

   genvar p;
   generate
      for (p = 0; p < UHP_NPIPE; p++) begin : g_pipe
         localparam logic [UHP_AW-1:0] CFG_OFF =
            UHP_OFF_CFG_BASE + UHP_AW'(p) * UHP_OFF_CFG_STRIDE;
         localparam int ALO = (p % UHP_ADDR_LO_PIPES) * UHP_ADDR_STRIDE;
         localparam logic [UHP_AW-1:0] ADDR_OFF =
            (p < UHP_ADDR_LO_PIPES) ? UHP_OFF_ADDR_LO : UHP_OFF_ADDR_HI;
         logic disabling;
         logic resetting;

         assign wr_cfg[p] = wr_hit(i_wr, i_addr, CFG_OFF); // R13
         assign disabling = wr_pen && pen_r[p]
            && !i_wdata[UHP_PEN_LSB + p];
         assign resetting = wr_pen && !prst_r[p]
            && i_wdata[UHP_PRST_LSB + p];

         always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
               addr_r[p] <= '0;
            end else if (i_bus_reset_req) begin
               addr_r[p] <= '0; // R6
            end else if (wr_hit(i_wr, i_addr, ADDR_OFF)) begin
               addr_r[p] <= i_wdata[ALO +: UHP_ADDR_W]; // R5
            end
         end

         // Allocation, bank count and size survive disable and reset
         always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
               pipe_memory_allocate_r[p] <= 1'b0;
               pbk_r[p] <= '0;
               pipe_bank_size_r[p] <= '0;
            end else if (i_bus_reset_req) begin
               pipe_memory_allocate_r[p] <= 1'b0; // R16
               pbk_r[p] <= '0;
               pipe_bank_size_r[p] <= '0; // R17
            end else if (wr_cfg[p]) begin
               pipe_memory_allocate_r[p] <= i_wdata[UHP_PIPE_MEMORY_ALLOCATE_BIT]; // R15
               pbk_r[p] <= i_wdata[UHP_PBK_LSB +: 2]; // R19
               pipe_bank_size_r[p] <= i_wdata[UHP_PIPE_BANK_SIZE_LSB +: 3];
            end
         end

         // Token, type, endpoint and interval survive a pipe reset
         always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
               token_r[p] <= '0;
               pipe_transfer_type_r[p] <= '0;
               epnum_r[p] <= '0;
               pipe_polling_interval_r[p] <= '0;
            end else if (i_bus_reset_req) begin
               pipe_transfer_type_r[p] <= '0;
               epnum_r[p] <= '0;
               pipe_polling_interval_r[p] <= '0;
            end else if (disabling) begin
               token_r[p] <= '0; // R8
               pipe_transfer_type_r[p] <= '0;
               epnum_r[p] <= '0;
               pipe_polling_interval_r[p] <= '0;
            end else if (wr_cfg[p]) begin
               if (i_wdata[UHP_TOKEN_LSB +: 2] != UHP_TOKEN_RSVD) begin
                  token_r[p] <= i_wdata[UHP_TOKEN_LSB +: 2]; // R18
               end
               pipe_transfer_type_r[p] <= i_wdata[UHP_PIPE_TRANSFER_TYPE_LSB +: 2]; // R19
               epnum_r[p] <= i_wdata[UHP_EPNUM_LSB +: 4];
               pipe_polling_interval_r[p] <= i_wdata[UHP_PIPE_POLLING_INTERVAL_LSB +: 8];
            end
         end

         always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
               auto_bank_switch_r[p] <= 1'b0;
            end else if (i_bus_reset_req || disabling) begin
               auto_bank_switch_r[p] <= 1'b0; // R8
            end else if (resetting) begin
               auto_bank_switch_r[p] <= 1'b0; // R9
            end else if (wr_cfg[p]) begin
               auto_bank_switch_r[p] <= i_wdata[UHP_AUTO_BANK_SWITCH_BIT];
            end
         end

         always_comb begin
            cfg_word[p] = '0;
            cfg_word[p][UHP_PIPE_MEMORY_ALLOCATE_BIT] = pipe_memory_allocate_r[p];
            cfg_word[p][UHP_PBK_LSB +: 2] = pbk_r[p];
            cfg_word[p][UHP_PIPE_BANK_SIZE_LSB +: 3] = pipe_bank_size_r[p];
            cfg_word[p][UHP_TOKEN_LSB +: 2] = token_r[p];
            cfg_word[p][UHP_AUTO_BANK_SWITCH_BIT] = auto_bank_switch_r[p];
            cfg_word[p][UHP_PIPE_TRANSFER_TYPE_LSB +: 2] = pipe_transfer_type_r[p];
            cfg_word[p][UHP_EPNUM_LSB +: 4] = epnum_r[p];
            cfg_word[p][UHP_PIPE_POLLING_INTERVAL_LSB +: 8] = pipe_polling_interval_r[p];
         end

         // Reserved memory: banks times bank size while allocated
         assign o_pipe_mem_bytes[p] = pipe_memory_allocate_r[p]
            ? UHP_MEM_W'(bank_bytes(pipe_bank_size_r[p]) * (pbk_r[p] + 2'h1))
            : '0; // R14
      end
   endgenerate

   assign o_pipe_dev_addr = addr_r;
   assign o_pipe_token = token_r;
   assign o_pipe_type = pipe_transfer_type_r;
   assign o_pipe_epnum = epnum_r;
   assign o_pipe_interval = pipe_polling_interval_r;
   assign o_pipe_auto_bank_switch = auto_bank_switch_r;

   // Read decode; write-only and unmapped words read as zero
   always_comb begin
      rd_nxt = '0;
      unique case (i_addr)
         UHP_OFF_IRQ_STATUS: rd_nxt = status_r;
         UHP_OFF_IRQ_MASK: rd_nxt = mask_r;
         UHP_OFF_IRQ_MASK_SET: rd_nxt = '0; // R1
         UHP_OFF_PIPE_EN: begin
            rd_nxt[UHP_PEN_LSB +: UHP_NPIPE] = pen_r;
            rd_nxt[UHP_PRST_LSB +: UHP_NPIPE] = prst_r;
         end
         UHP_OFF_FRAME: begin
            rd_nxt[UHP_FRAME_NUMBER_LSB +: UHP_FRAME_NUMBER_W] = frame_number_r;
            rd_nxt[UHP_FLEN_LSB +: UHP_FLEN_W] =
               fcount[UHP_FCNT_W-1 -: UHP_FLEN_W]; // R4
         end
         default: begin
            for (int i = 0; i < UHP_NPIPE; i++) begin
               if (i < UHP_ADDR_LO_PIPES && i_addr == UHP_OFF_ADDR_LO) begin
                  rd_nxt[i*UHP_ADDR_STRIDE +: UHP_ADDR_W] = addr_r[i];
               end
               if (i >= UHP_ADDR_LO_PIPES && i_addr == UHP_OFF_ADDR_HI) begin
                  rd_nxt[(i-UHP_ADDR_LO_PIPES)*UHP_ADDR_STRIDE +: UHP_ADDR_W]
                     = addr_r[i];
               end
               if (i_addr == UHP_OFF_CFG_BASE
                     + UHP_AW'(i) * UHP_OFF_CFG_STRIDE) begin
                  rd_nxt = cfg_word[i];
               end
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         rd_data_r <= '0;
      end else if (i_rd) begin
         rd_data_r <= rd_nxt;
      end else begin
         rd_data_r <= '0;
      end
   end

   assign o_rdata = rd_data_r;

   // Cycles between starts of frame, for checking only
   logic [15:0] gap_r;
   logic seen_r;

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         gap_r <= '0;
         seen_r <= 1'b0;
      end else if (sof) begin
         gap_r <= '0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 16'h0001;
      end
   end

   property p_mask_set;
      @(posedge i_core_clk) disable iff (!i_resetn)
      wr_hit(i_wr, i_addr, UHP_OFF_IRQ_MASK_SET) |=>
         ((mask_r & $past(i_wdata) & UHP_IRQ_VALID)
          == ($past(i_wdata) & UHP_IRQ_VALID))
         && ((mask_r & $past(mask_r)) == $past(mask_r));
   endproperty
   a_mask_set: assert property (p_mask_set) // R1
      else $error("enable set write did not set enables");

   property p_frame_number_load;
      @(posedge i_core_clk) disable iff (!i_resetn)
      wr_hit(i_wr, i_addr, UHP_OFF_FRAME) |=>
         frame_number_r == $past(i_wdata[UHP_FRAME_NUMBER_LSB +: UHP_FRAME_NUMBER_W]);
   endproperty
   a_frame_number_load: assert property (p_frame_number_load) // R2
      else $error("frame number not loaded by write");

   property p_sof_period;
      @(posedge i_core_clk) disable iff (!i_resetn)
      sof && seen_r |-> gap_r == 16'(FRAME_CYCLES - 1);
   endproperty
   a_sof_period: assert property (p_sof_period) // R3
      else $error("start of frame spacing wrong");

   property p_frame_number_step;
      @(posedge i_core_clk) disable iff (!i_resetn)
      sof && !wr_hit(i_wr, i_addr, UHP_OFF_FRAME) |=>
         frame_number_r == $past(frame_number_r) + 11'h001;
   endproperty
   a_frame_number_step: assert property (p_frame_number_step) // R3
      else $error("frame number did not advance");

   property p_flen_read;
      @(posedge i_core_clk) disable iff (!i_resetn)
      i_rd && i_addr == UHP_OFF_FRAME |=>
         o_rdata[UHP_FLEN_LSB +: UHP_FLEN_W]
            == $past(fcount[UHP_FCNT_W-1 -: UHP_FLEN_W]);
   endproperty
   a_flen_read: assert property (p_flen_read) // R4
      else $error("frame length field wrong");

   property p_addr_clear;
      @(posedge i_core_clk) disable iff (!i_resetn)
      i_bus_reset_req |=> o_pipe_dev_addr == '0 && pipe_memory_allocate_r == '0;
   endproperty
   a_addr_clear: assert property (p_addr_clear) // R6
      else $error("bus reset left address or allocation");

   property p_pen;
      @(posedge i_core_clk) disable iff (!i_resetn)
      wr_pen |=> o_pipe_active == $past(i_wdata[UHP_NPIPE-1:0])
         && o_pipe_fifo_reset
            == $past(i_wdata[UHP_PRST_LSB +: UHP_NPIPE]);
   endproperty
   a_pen: assert property (p_pen) // R7
      else $error("pipe enable or reset not taken");

   property p_disable_keeps;
      @(posedge i_core_clk) disable iff (!i_resetn)
      g_pipe[0].disabling && !i_bus_reset_req |=>
         pipe_memory_allocate_r[0] == $past(pipe_memory_allocate_r[0])
         && pipe_bank_size_r[0] == $past(pipe_bank_size_r[0]) && pipe_transfer_type_r[0] == 2'h0;
   endproperty
   a_disable_keeps: assert property (p_disable_keeps) // R8
      else $error("pipe disable handled configuration wrongly");

   property p_irq;
      @(posedge i_core_clk) disable iff (!i_resetn)
      sof && mask_r[UHP_IRQ_SOF] |=> o_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled frame event gave no interrupt");

   c_sof: cover property (@(posedge i_core_clk) sof && seen_r);
   c_bus_reset: cover property (@(posedge i_core_clk) i_bus_reset_req);
   c_pipe_memory_allocate: cover property (@(posedge i_core_clk) pipe_memory_allocate_r[0]);
   c_irq: cover property (@(posedge i_core_clk) o_irq);

endmodule : uhp_host_ctrl
`default_nettype wire

//--- tb/uhp_far_model.sv
// Far side of the host block: USB bus events.
// Assumes bench requests arrive on the core clock.
`timescale 1ns/1ps
`default_nettype none
module uhp_far_model (
   // Clock
   input wire logic i_core_clk,
   // Requests from the bench
   input wire logic i_do_reset,
   input wire logic i_do_wake,
   // Bus events
   output logic o_bus_reset_req,
   output logic o_wakeup
);
   // Event outputs follow the requests one core cycle later
   always_ff @(posedge i_core_clk) begin
      o_bus_reset_req <= i_do_reset;
      o_wakeup <= i_do_wake;
   end
endmodule : uhp_far_model
`default_nettype wire

//--- tb/uhp_host_ctrl_bench.sv
// Bench of the host frame and pipe control block.
// Assumes FRAME_LEN 120: one frame every 100 core cycles.
`timescale 1ns/1ps
`default_nettype none
module uhp_host_ctrl_bench;
   import uhp_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic do_rst = 1'b0, do_wake = 1'b0, ev_rs = 1'b0, ev_up = 1'b0;
   logic [6:0] ev_p = 7'h00;
   logic [5:0] ev_d = 6'h00;
   logic bus_rst, wake, sof, irq;
   logic [10:0] frame_number;
   logic [6:0] act, fifo, asw;
   logic [6:0][6:0] dev;
   logic [6:0][1:0] tok, ptyp;
   logic [6:0][3:0] ep;
   logic [6:0][7:0] intv;
   logic [6:0][11:0] mem;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   uhp_host_ctrl #(.FRAME_LEN(120)) i_dut (.i_core_clk(clk),
      .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_bus_reset_req(bus_rst),
      .i_resume_sent(ev_rs), .i_upstream_resume(ev_up), .i_wakeup(wake),
      .i_pipe_event(ev_p), .i_dma_event(ev_d), .o_sof(sof),
      .o_frame_number(frame_number), .o_pipe_active(act),
      .o_pipe_fifo_reset(fifo), .o_pipe_dev_addr(dev),
      .o_pipe_token(tok), .o_pipe_type(ptyp), .o_pipe_epnum(ep),
      .o_pipe_interval(intv), .o_pipe_auto_bank_switch(asw),
      .o_pipe_mem_bytes(mem), .o_irq(irq));
   uhp_far_model i_far (.i_core_clk(clk), .i_do_reset(do_rst),
      .i_do_wake(do_wake), .o_bus_reset_req(bus_rst), .o_wakeup(wake));
   initial begin
      forever #50 clk = ~clk;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task rd_reg(input logic [11:0] a, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      q = rdata;
   endtask : rd_reg
   task t_regs;
      logic [11:0] tbl [9];
      logic [31:0] q;
      tbl = '{12'h41c, 12'h420, 12'h424, 12'h428, 12'h500, 12'h518,
         12'h410, 12'h404, 12'h40c};
      foreach (tbl[i]) begin
         rd_reg(tbl[i], q);
         chk(q, 32'h0);
      end
      $display("t_regs done");
   endtask : t_regs
   task t_frame;
      logic [31:0] q;
      logic [10:0] f;
      int n;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (sof !== 1'b1 && n < 200);
      n = 0;
      do begin @(posedge clk); #1; n++; end while (sof !== 1'b1 && n < 200);
      chk(n, 100);
      f = frame_number;
      @(posedge clk);
      #1;
      chk(frame_number, f + 11'h1);
      wr_reg(12'h420, 32'h0000_0918);
      rd_reg(12'h420, q);
      chk(q, 32'h0000_0918);
      repeat (60) @(posedge clk);
      rd_reg(12'h420, q);
      chk(q, 32'h0001_0918);
      $display("t_frame done");
   endtask : t_frame
   task t_irq;
      logic [31:0] q;
      wr_reg(12'h418, 32'h0000_0040);
      wr_reg(12'h418, 32'h0);
      rd_reg(12'h418, q);
      chk(q, 32'h0);
      rd_reg(12'h410, q);
      chk(q, 32'h40);
      chk(irq, 1'b0);
      @(posedge clk);
      do_wake <= 1'b1;
      @(posedge clk);
      do_wake <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(irq, 1'b1);
      wr_reg(12'h408, 32'h40);
      chk(irq, 1'b0);
      wr_reg(12'h418, 32'hffff_ffff);
      rd_reg(12'h410, q);
      chk(q, 32'h7e00_7f78);
      wr_reg(12'h414, 32'hffff_ffff);
      @(posedge clk);
      ev_rs <= 1'b1;
      ev_up <= 1'b1;
      ev_p <= 7'h7f;
      ev_d <= 6'h3f;
      @(posedge clk);
      ev_rs <= 1'b0;
      ev_up <= 1'b0;
      ev_p <= 7'h00;
      ev_d <= 6'h00;
      rd_reg(12'h404, q);
      chk(q, 32'h7e00_7f38);
      chk(irq, 1'b0);
      $display("t_irq done");
   endtask : t_irq
   task t_cfg;
      logic [31:0] q;
      wr_reg(12'h508, 32'h5a09_2536);
      rd_reg(12'h508, q);
      chk(q, 32'h5a09_2536);
      chk({ptyp[2], ep[2], intv[2], asw[2]}, {2'h2, 4'h9, 8'h5a, 1'b1});
      chk(mem[2], 12'h080);
      wr_reg(12'h508, 32'h5a09_2736);
      chk(tok[2], 2'h1);
      wr_reg(12'h518, 32'h0000_0200);
      chk({tok[6], tok[2]}, 4'h9);
      for (int c = 0; c < 3; c++) begin
         wr_reg(12'h508, 32'h2 | (c << 8));
         chk(tok[2], c);
      end
      for (int c = 0; c < 8; c++) begin
         wr_reg(12'h508, c << 4);
         chk(mem[2], 12'h000);
         wr_reg(12'h508, 32'h2 | (c << 4));
         chk(mem[2], 12'h008 << c);
      end
      $display("t_cfg done");
   endtask : t_cfg
   task t_pipe;
      wr_reg(12'h508, 32'h0000_0572);
      wr_reg(12'h41c, 32'h0000_0004);
      chk(act, 7'h04);
      wr_reg(12'h41c, 32'h0004_0004);
      chk({act[2], fifo[2], tok[2], asw[2]}, 5'b11010);
      wr_reg(12'h41c, 32'h0000_0004);
      chk({act[2], fifo[2]}, 2'b10);
      wr_reg(12'h41c, 32'h0);
      chk({act[2], tok[2], mem[2]}, {3'b000, 12'h400});
      $display("t_pipe done");
   endtask : t_pipe
   task t_addr;
      logic [31:0] q;
      wr_reg(12'h424, 32'hff55_2a85);
      wr_reg(12'h428, 32'h0003_0201);
      rd_reg(12'h424, q);
      chk(q, 32'h7f55_2a05);
      chk({dev[6], dev[3], dev[0]}, {7'h03, 7'h7f, 7'h05});
      @(posedge clk);
      do_rst <= 1'b1;
      @(posedge clk);
      do_rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(dev[3:0], 32'h0);
      chk(dev[6:4], 32'h0);
      chk(mem[2], 12'h000);
      $display("t_addr done");
   endtask : t_addr
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_frame();
      t_irq();
      t_cfg();
      t_pipe();
      t_addr();
      stop_test();
   end
endmodule : uhp_host_ctrl_bench
`default_nettype wire
